//--- design/thermal_irq_pkg.sv
// constants for the thermal monitor and interrupt block
package thermal_irq_pkg;
	localparam logic [7:0] FLAGS_OFFSET = 8'h0B;
	localparam logic [7:0] MASKS_OFFSET = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET = 8'h0A;
	localparam logic [7:0] CONFIG_OFFSET = 8'h09;
	localparam int TRIP_BIT = 0;
	localparam int WARN_BIT = 1;
	localparam int KEEP_BIT = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASKS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int OSC_NOM_KHZ = 2000;
	localparam int OSC_MIN_KHZ = 1900;
	localparam int OSC_MAX_KHZ = 2100;
	localparam int CLK_KHZ = 125000;
	localparam int WARN_CELSIUS = 125;
	localparam int TRIP_CELSIUS = 160;
	localparam int COOL_CELSIUS = 115;
	localparam int TEMP_W = 9;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SHUT = 2'b01,
		ST_RESTART = 2'b11
	} therm_state_t;
endpackage : thermal_irq_pkg

//--- design/therm_cmp.sv
// threshold comparator for the die temperature reading
`timescale 1ns/1ns
`default_nettype none
module therm_cmp #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// reading and thresholds
	input wire logic [W-1:0] temp,
	input wire logic [W-1:0] warn_th,
	input wire logic [W-1:0] trip_th,
	input wire logic [W-1:0] cool_th,
	// registered comparisons
	output logic warn_hi,
	output logic trip_hi,
	output logic cooled
);
	wire logic warn_nxt = temp > warn_th;
	wire logic trip_nxt = temp > trip_th;
	wire logic cool_nxt = temp <= cool_th;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			warn_hi <= 1'b0;
			trip_hi <= 1'b0;
			cooled <= 1'b1;
		end else begin
			warn_hi <= warn_nxt;
			trip_hi <= trip_nxt;
			cooled <= cool_nxt;
		end
	end
endmodule : therm_cmp
`default_nettype wire

//--- design/thermal_monitor_interrupt.sv
// thermal monitor with latched interrupt flags, masks and restart gating
// Functional notes
// - trip interrupt flag reads 1 after a shutdown event, else 0.
// - early warning flag reads 1 after a warning interrupt, else 0.
// - mask bit 1 blocks the trip source; 0 lets it through.
// - mask bit 1 blocks the warning source; 0 lets it through.
// - warning threshold exceeded drives the active-low interrupt low.
// - warning crossing sets warning bit in status and flag registers.
// - trip threshold exceeded starts emergency shutdown of outputs.
// - after shutdown, power-up waits until die cools to recovery threshold.
// - logic runs from a nominal 2.0 MHz oscillator, 1.9 to 2.1 MHz.
// - status shutdown bit is 1 while in thermal shutdown, else 0.
// - with enable high after cooling, restart; reset registers unless keep bit set.
`timescale 1ns/1ns
`default_nettype none
module thermal_monitor_interrupt
	import thermal_irq_pkg::*;
#(
	parameter int W = thermal_irq_pkg::TEMP_W,
	parameter logic [8:0] WARN_TH = 9'(thermal_irq_pkg::WARN_CELSIUS),
	parameter logic [8:0] TRIP_TH = 9'(thermal_irq_pkg::TRIP_CELSIUS),
	parameter logic [8:0] COOL_TH = 9'(thermal_irq_pkg::COOL_CELSIUS)
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// temperature reading in degrees, unsigned
	input wire logic [W-1:0] temp,
	// enable pin
	input wire logic en,
	// register port
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// open-drain interrupt, low active
	output logic irq_n_o,
	output logic irq_n_oe,
	// power control
	output logic outputs_off,
	output logic startup_req,
	output logic regs_default
);
	import thermal_irq_pkg::*;

	// clk is the control oscillator; nothing here depends on its exact rate
	// so drift inside the allowed band only stretches every delay in real time
	localparam bit OSC_RANGE_OK = (OSC_NOM_KHZ >= OSC_MIN_KHZ) && (OSC_NOM_KHZ <= OSC_MAX_KHZ);

	logic warn_hi;
	logic trip_hi;
	logic cooled;
	// readings are compared one cycle late, so every event trails temp by a clock
	therm_cmp #(.W(W)) u_cmp (
		.clk(clk),
		.nrst(nrst),
		.temp(temp),
		.warn_th(WARN_TH[W-1:0]),
		.trip_th(TRIP_TH[W-1:0]),
		.cool_th(COOL_TH[W-1:0]),
		.warn_hi(warn_hi),
		.trip_hi(trip_hi),
		.cooled(cooled)
	);

	therm_state_t state_r;
	therm_state_t state_nxt;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] masks_r;
	logic [7:0] masks_nxt;
	logic [7:0] config_r;
	logic [7:0] config_nxt;
	logic warn_prev_r;
	logic [7:0] rdata_nxt;

	wire logic rd_flags = reg_rd && (reg_addr == FLAGS_OFFSET);
	wire logic wr_masks = reg_wr && (reg_addr == MASKS_OFFSET);
	wire logic wr_config = reg_wr && (reg_addr == CONFIG_OFFSET);
	wire logic warn_rise = warn_hi && !warn_prev_r;
	wire logic trip_event = trip_hi && (state_r == ST_RUN);
	wire logic in_shut = (state_r == ST_SHUT);
	wire logic keep_regs_after_overheat = config_r[KEEP_BIT];
	wire logic restart_go = in_shut && cooled && en;
	wire logic do_default = (state_r == ST_RESTART) && !keep_regs_after_overheat;

	// status: shutdown state and live warning level
	wire logic overheat_shutdown_state = in_shut;
	wire logic [7:0] status_val = {6'h00, warn_hi, overheat_shutdown_state};

	// a pending event wins over the read-to-clear
	wire logic trip_set = trip_event || trip_hi;
	wire logic warn_set = warn_rise || warn_hi;
	wire logic overheat_trip_irq_flag = flags_r[TRIP_BIT];
	wire logic early_warn_flag = flags_r[WARN_BIT];
	wire logic overheat_trip_irq_mask = masks_r[TRIP_BIT];
	wire logic early_warn_irq_mask = masks_r[WARN_BIT];
	wire logic trip_live = overheat_trip_irq_flag && !overheat_trip_irq_mask;
	wire logic warn_live = early_warn_flag && !early_warn_irq_mask;
	wire logic irq_nxt = trip_live || warn_live;

	// only the two source bits ever move; the upper bits stay zero
	always_comb begin
		flags_nxt = flags_r;
		if (rd_flags) begin
			flags_nxt = FLAGS_RESET;
		end
		if (trip_set) begin
			flags_nxt[TRIP_BIT] = 1'b1;
		end
		if (warn_set) begin
			flags_nxt[WARN_BIT] = 1'b1;
		end
	end

	// defaults win over a write in the restart cycle; such a write is lost
	always_comb begin
		masks_nxt = masks_r;
		config_nxt = config_r;
		if (do_default) begin
			masks_nxt = MASKS_RESET;
			config_nxt = CONFIG_RESET;
		end else begin
			if (wr_masks) begin
				masks_nxt = {6'h00, reg_wdata[WARN_BIT], reg_wdata[TRIP_BIT]};
			end
			if (wr_config) begin
				config_nxt = {reg_wdata[KEEP_BIT], 7'h00};
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (trip_hi) begin
					state_nxt = ST_SHUT;
				end
			end
			ST_SHUT: begin
				if (restart_go) begin
					state_nxt = ST_RESTART;
				end
			end
			ST_RESTART: begin
				// one cycle only, so the defaults land before normal running resumes
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always_comb begin
		case (reg_addr)
			STATUS_OFFSET: rdata_nxt = status_val;
			FLAGS_OFFSET: rdata_nxt = {6'h00, early_warn_flag, overheat_trip_irq_flag};
			MASKS_OFFSET: rdata_nxt = {6'h00, early_warn_irq_mask, overheat_trip_irq_mask};
			CONFIG_OFFSET: rdata_nxt = {keep_regs_after_overheat, 7'h00};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_RUN;
			flags_r <= FLAGS_RESET;
			masks_r <= MASKS_RESET;
			config_r <= CONFIG_RESET;
			warn_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			flags_r <= flags_nxt;
			masks_r <= masks_nxt;
			config_r <= config_nxt;
			warn_prev_r <= warn_hi;
		end
	end

	// read answer holds until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end

	// open-drain pin: level fixed low and only the enable moves, so the pin never drives high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_n_o <= 1'b0;
			irq_n_oe <= 1'b0;
		end else begin
			irq_n_o <= 1'b0;
			irq_n_oe <= irq_nxt;
		end
	end

	// power control; the masks default here, regs_default tells the rest of the unit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outputs_off <= 1'b0;
			startup_req <= 1'b0;
			regs_default <= 1'b0;
		end else begin
			outputs_off <= (state_nxt == ST_SHUT);
			startup_req <= (state_r == ST_SHUT) && (state_nxt == ST_RESTART);
			regs_default <= (state_r == ST_SHUT) && restart_go && !keep_regs_after_overheat;
		end
	end

	// mask changes land a cycle before the pin follows, hence the past values below
	a_trip_shuts: assert property (@(posedge clk) disable iff (!nrst)
		trip_hi && state_r == ST_RUN |=> outputs_off && state_r == ST_SHUT)
		else $error("trip did not shut outputs");
	a_no_early_restart: assert property (@(posedge clk) disable iff (!nrst)
		in_shut && !cooled |=> state_r == ST_SHUT)
		else $error("restart before cooling");
	a_status_shut: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == STATUS_OFFSET |=> reg_rdata[TRIP_BIT] == $past(outputs_off))
		else $error("status shutdown bit wrong");
	a_irq_follows: assert property (@(posedge clk) disable iff (!nrst)
		(flags_r[WARN_BIT] && !masks_r[WARN_BIT]) |=> irq_n_oe)
		else $error("unmasked flag without interrupt");
	a_mask_blocks: assert property (@(posedge clk) disable iff (!nrst)
		(masks_r[TRIP_BIT] && masks_r[WARN_BIT]) |=> !irq_n_oe)
		else $error("masked source pulled interrupt");
	a_warn_sets: assert property (@(posedge clk) disable iff (!nrst)
		warn_hi |=> flags_r[WARN_BIT] ##1 (irq_n_oe || $past(masks_r[WARN_BIT])))
		else $error("warning not latched");
	a_flag_holds: assert property (@(posedge clk) disable iff (!nrst)
		flags_r[TRIP_BIT] && !rd_flags |=> flags_r[TRIP_BIT])
		else $error("trip flag lost without read");
	a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
		rd_flags && !warn_hi && !trip_hi && !$past(warn_hi) |=> !flags_r[WARN_BIT])
		else $error("read did not clear warning flag");
	a_warn_mask: assert property (@(posedge clk) disable iff (!nrst)
		wr_masks && !do_default |=> masks_r[WARN_BIT] == $past(reg_wdata[WARN_BIT]))
		else $error("warning mask not stored");
	a_default_restart: assert property (@(posedge clk) disable iff (!nrst)
		state_r == ST_RESTART && !config_r[KEEP_BIT] |=> masks_r == MASKS_RESET)
		else $error("registers not defaulted");
	a_trip_flag_sets: assert property (@(posedge clk) disable iff (!nrst)
		trip_hi |=> flags_r[TRIP_BIT])
		else $error("trip flag not set");
	a_trip_flag_zero: assert property (@(posedge clk) disable iff (!nrst)
		!flags_r[TRIP_BIT] && !trip_hi |=> !flags_r[TRIP_BIT])
		else $error("trip flag set without cause");
	a_warn_flag_zero: assert property (@(posedge clk) disable iff (!nrst)
		!flags_r[WARN_BIT] && !warn_hi |=> !flags_r[WARN_BIT])
		else $error("warning flag set without cause");
	a_trip_mask: assert property (@(posedge clk) disable iff (!nrst)
		wr_masks && !do_default |=> masks_r[TRIP_BIT] == $past(reg_wdata[TRIP_BIT]))
		else $error("trip mask not stored");
	a_trip_masked: assert property (@(posedge clk) disable iff (!nrst)
		masks_r[TRIP_BIT] && !(flags_r[WARN_BIT] && !masks_r[WARN_BIT]) |=> !irq_n_oe)
		else $error("masked trip pulled interrupt");
	a_warn_masked: assert property (@(posedge clk) disable iff (!nrst)
		masks_r[WARN_BIT] && !(flags_r[TRIP_BIT] && !masks_r[TRIP_BIT]) |=> !irq_n_oe)
		else $error("masked warning pulled interrupt");
	a_pin_low: assert property (@(posedge clk) disable iff (!nrst)
		!irq_n_o)
		else $error("interrupt pin level not low");
	a_warn_status: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == STATUS_OFFSET && warn_hi |=> reg_rdata[WARN_BIT])
		else $error("status warning bit missing");
	a_off_in_shut: assert property (@(posedge clk) disable iff (!nrst)
		outputs_off == (state_r == ST_SHUT))
		else $error("outputs off out of step with shutdown");
	a_shut_stays: assert property (@(posedge clk) disable iff (!nrst)
		in_shut |=> state_r == ST_SHUT || state_r == ST_RESTART)
		else $error("shutdown left without restart");
	a_restart_en: assert property (@(posedge clk) disable iff (!nrst)
		in_shut && !en |=> state_r == ST_SHUT)
		else $error("restart with enable low");
	a_restart_pulse: assert property (@(posedge clk) disable iff (!nrst)
		startup_req |=> !startup_req)
		else $error("startup request longer than one cycle");
	a_default_pulse: assert property (@(posedge clk) disable iff (!nrst)
		regs_default |-> startup_req)
		else $error("defaults without restart");
	a_keep_masks: assert property (@(posedge clk) disable iff (!nrst)
		state_r == ST_RESTART && config_r[KEEP_BIT] && !wr_masks |=> masks_r == $past(masks_r))
		else $error("masks lost with keep bit set");
	a_cfg_store: assert property (@(posedge clk) disable iff (!nrst)
		wr_config && !do_default |=> config_r[KEEP_BIT] == $past(reg_wdata[KEEP_BIT]))
		else $error("keep bit not stored");
	a_trip_irq: assert property (@(posedge clk) disable iff (!nrst)
		flags_r[TRIP_BIT] && !masks_r[TRIP_BIT] |=> irq_n_oe)
		else $error("unmasked trip without interrupt");
	a_irq_release: assert property (@(posedge clk) disable iff (!nrst)
		!(flags_r[TRIP_BIT] && !masks_r[TRIP_BIT]) && !(flags_r[WARN_BIT] && !masks_r[WARN_BIT]) |=> !irq_n_oe)
		else $error("interrupt held without unmasked flag");

	c_shutdown: cover property (@(posedge clk) disable iff (!nrst) state_r == ST_SHUT);
	c_restart: cover property (@(posedge clk) disable iff (!nrst) startup_req);
	c_warn_irq: cover property (@(posedge clk) disable iff (!nrst) warn_rise ##2 irq_n_oe);
	c_read_clear: cover property (@(posedge clk) disable iff (!nrst) rd_flags && flags_r[WARN_BIT] ##1 !flags_r[WARN_BIT]);
	c_keep_restart: cover property (@(posedge clk) disable iff (!nrst)
		state_r == ST_RESTART && config_r[KEEP_BIT]);
endmodule : thermal_monitor_interrupt
`default_nettype wire

//--- verification/host_model.sv
// host side model: register port master and pulled-up interrupt line
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// open-drain interrupt
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	output logic irq_line
);
	// board pull-up holds the line high while nobody drives it
	assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		// idle bus shows no stale value
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : host_model
`default_nettype wire

//--- verification/test_thermal_monitor_interrupt.sv
// self-checking bench for the thermal monitor and interrupt block
`timescale 1ns/1ns
`default_nettype none
module test_thermal_monitor_interrupt;
	import thermal_irq_pkg::*;
	logic clk, nrst, en, reg_rd, reg_wr, irq_n_o, irq_n_oe, irq_line, outputs_off, startup_req, regs_default, dflt;
	logic [8:0] temp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	int miscompares = 0;
	int n_tests = 0;
	thermal_monitor_interrupt dut (.clk(clk), .nrst(nrst), .temp(temp), .en(en), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .outputs_off(outputs_off), .startup_req(startup_req),
		.regs_default(regs_default));
	host_model host (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
		.irq_line(irq_line));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic results;
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bchk(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : bchk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	task automatic wait_start;
		for (int i = 0; i < 50 && startup_req !== 1'b1; i++) begin
			idle(1);
		end
		if (startup_req !== 1'b1) begin
			miscompares++;
			results();
		end
		dflt = regs_default;
	endtask : wait_start
	initial begin
		#200000;
		miscompares++;
		results();
	end
	initial begin
		nrst = 1'b0;
		temp = 9'h019;
		en = 1'b0;
		dflt = 1'b0;
		idle(20);
		nrst = 1'b1;
		rchk(FLAGS_OFFSET, FLAGS_RESET);
		rchk(MASKS_OFFSET, MASKS_RESET);
		rchk(8'h3F, 8'h00);
		host.wr(FLAGS_OFFSET, 8'hFF);
		rchk(FLAGS_OFFSET, 8'h00);
		bchk(irq_line, 1'b1);
		// warning while masked, then unmasked; 126 is just over the threshold
		host.wr(MASKS_OFFSET, 8'h02);
		rchk(MASKS_OFFSET, 8'h02);
		temp = 9'h07E;
		idle(5);
		bchk(irq_line, 1'b1);
		rchk(STATUS_OFFSET, 8'h02);
		host.wr(MASKS_OFFSET, 8'h00);
		idle(3);
		bchk(irq_line, 1'b0);
		temp = 9'h064;
		idle(4);
		bchk(irq_line, 1'b0);
		rchk(FLAGS_OFFSET, 8'h02);
		rchk(FLAGS_OFFSET, 8'h00);
		idle(3);
		bchk(irq_line, 1'b1);
		// trip at 161, hold at 116, restart at 115 with registers defaulted
		en = 1'b1;
		temp = 9'h0A1;
		idle(3);
		bchk(outputs_off, 1'b1);
		bchk(irq_line, 1'b0);
		rchk(STATUS_OFFSET, 8'h03);
		temp = 9'h074;
		rchk(FLAGS_OFFSET, 8'h03);
		rchk(FLAGS_OFFSET, 8'h00);
		host.wr(MASKS_OFFSET, 8'h02);
		idle(20);
		bchk(outputs_off, 1'b1);
		temp = 9'h073;
		wait_start();
		bchk(dflt, 1'b1);
		idle(2);
		bchk(outputs_off, 1'b0);
		rchk(STATUS_OFFSET, 8'h00);
		rchk(MASKS_OFFSET, 8'h00);
		// keep bit set, both sources masked
		host.wr(CONFIG_OFFSET, 8'h80);
		host.wr(MASKS_OFFSET, 8'h03);
		temp = 9'h0A1;
		idle(5);
		bchk(outputs_off, 1'b1);
		bchk(irq_line, 1'b1);
		temp = 9'h050;
		wait_start();
		bchk(dflt, 1'b0);
		idle(2);
		rchk(MASKS_OFFSET, 8'h03);
		// reset in mid-run with flags pending and the keep bit set
		nrst = 1'b0;
		idle(2);
		bchk(irq_line, 1'b1);
		bchk(startup_req, 1'b0);
		nrst = 1'b1;
		rchk(FLAGS_OFFSET, FLAGS_RESET);
		rchk(MASKS_OFFSET, MASKS_RESET);
		rchk(CONFIG_OFFSET, CONFIG_RESET);
		results();
	end
endmodule : test_thermal_monitor_interrupt
`default_nettype wire
